// ===== inc/irs_pkg.sv
// constants, field layout and carrier types for the initial reset and system config block
// assumes a 200 MHz core clock and a 24-bit cpu memory address space
package irs_pkg;
	// memory-mapped system control registers
	localparam logic [23:0] CFG_BUS_ADDR   = 24'h00ff00;
	localparam logic [23:0] CFG_STACK_ADDR = 24'h00ff01;
	localparam logic [23:0] CFG_WAIT_ADDR  = 24'h00ff02;
	// reset values in microcontroller mode: single chip, chip selects off
	localparam logic [7:0]  CFG_BUS_RST    = 8'h30;
	localparam logic [7:0]  CFG_STACK_RST  = 8'h00;
	localparam logic [7:0]  CFG_WAIT_RST   = 8'h00;
	// field positions
	localparam int          BUS_MODE_BIT   = 6;
	localparam int          CS_EN_LSB      = 0;
	localparam int          CS_EN_W        = 4;
	localparam int          REL_EN_BIT     = 7;
	localparam int          WAIT_LSB       = 4;
	localparam int          WAIT_W         = 3;
	localparam int          CLK_SEL_BIT    = 3;
	localparam int          FOSC_EN_BIT    = 2;
	// reset vector and cpu register initial values
	localparam logic [23:0] VEC_LO_ADDR    = 24'h000000;
	localparam logic [23:0] VEC_HI_ADDR    = 24'h000001;
	localparam logic [7:0]  NEW_BANK_RST   = 8'h01;
	localparam logic [7:0]  PAGE_RST       = 8'h00;
	// oscillation stabilization wait
	localparam int          STAB_WAIT_US   = 250000;
	localparam int          CLK_FREQ_MHZ   = 200;
	localparam int          STAB_CYCLES    = STAB_WAIT_US * CLK_FREQ_MHZ;

	typedef struct packed {
		logic zero;
		logic carry;
		logic overflow;
		logic negative;
		logic decimal;
		logic unpack;
		logic maskLow;
		logic maskHigh;
	} irs_flags_s;

	localparam irs_flags_s FLAGS_RST = '{maskLow: 1'b1, maskHigh: 1'b1, default: 1'b0};

	typedef struct packed {
		logic [7:0] dataPage;
		logic [7:0] indexXPage;
		logic [7:0] indexYPage;
	} irs_pages_s;

	typedef enum logic [5:0] {
		ST_HOLD = 6'b000001,
		ST_STAB = 6'b000010,
		ST_VLO  = 6'b000100,
		ST_VHI  = 6'b001000,
		ST_LOAD = 6'b010000,
		ST_RUN  = 6'b100000
	} irs_state_e;
endpackage

// ===== rtl/irs_initial_reset.sv
// initial reset sequencer, cpu reset values and the three system control registers
// assumes rst_n is the external reset pin; cpu core fetches with one-cycle read latency
module irs_initial_reset #(
	parameter int STAB_CYCLES = irs_pkg::STAB_CYCLES
) (
	input  wire logic               core_clk,    // 200 mhz core clock
	input  wire logic               rst_n,       // external reset pin, async
	output logic                    cpuRun,      // cpu may execute
	output logic                    periphRst_n, // peripheral init hold
	output logic                    fetchReq,    // vector read strobe
	output logic [23:0]             fetchAddr,   // vector read address
	input  wire logic [7:0]         fetchData,   // vector byte, next cycle
	output logic [15:0]             progCounter, // loaded program counter
	output logic [7:0]              codeBankCurrent, // code bank register
	output logic [7:0]              newCodeBank, // new code bank register
	output irs_pkg::irs_flags_s     cpuFlags,    // cpu flag reset state
	output irs_pkg::irs_pages_s     cpuPages,    // expand page registers
	input  wire logic [23:0]        memAddr,     // cpu memory address
	input  wire logic               memWr,       // cpu write strobe
	input  wire logic               memRd,       // cpu read strobe
	input  wire logic [7:0]         memWrData,   // cpu write data
	output logic [7:0]              memRdData,   // register read data
	output logic                    memRdHit,    // read data valid
	output logic [7:0]              stackPageBits, // stack page select
	output logic                    cpuClockSelect, // fast clock chosen
	output logic                    fastOscEnable, // fast oscillator on
	output logic [1:0]              regulatorControl, // spare r/w bits
	input  wire logic               waitStart,   // t3 of a bus cycle
	input  wire logic               extAccess,   // cycle targets outside
	output logic                    busWait,     // stretch t3 to t4
	input  wire logic [3:0]         csDecode_n,  // decoded chip selects
	input  wire logic [3:0]         csPortData,  // port data for cs pins
	output logic [3:0]              csPin,       // chip select pin level
	input  wire logic               busRelReqPin_n, // request or port pin
	input  wire logic               busIdle,     // no bus cycle running
	input  wire logic               ackPortData, // port data for ack pin
	output logic                    inputPortPin, // synced port value
	output logic                    busRelAckPin_n, // acknowledge or port
	output logic                    busOe        // addr/data/rd/wr/cs drive
);
	irs_pkg::irs_state_e state_ff;
	irs_pkg::irs_state_e nxt_state;
	logic [2:0]  rstSync_ff;
	logic        released;
	logic [31:0] stabCnt_ff;
	logic [7:0]  vecLo_ff;
	logic [7:0]  cfgBus_ff;
	logic [7:0]  cfgStack_ff;
	logic [7:0]  cfgWait_ff;
	logic        singleChip;
	logic [3:0]  waitCnt_ff;
	logic        waitOk;
	logic [2:0]  reqSync_ff;
	logic        reqLow_ff;
	logic        relHiZ_ff;
	logic        relAck_ff;
	logic        relEn;

	// inserted states are half cycles, so the stretch in core cycles is half of this
	function automatic logic [3:0] waitStates(input logic [2:0] code);
		waitStates = {code, 1'b0};
	endfunction

	function automatic logic hit(input logic [23:0] a, input logic [23:0] b);
		hit = (a == b);
	endfunction

	// reset release passes three flops; the pin may drop at any time
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync_ff <= 3'h0;
		else
			rstSync_ff <= {rstSync_ff[1:0], 1'b1};
	end
	assign released = rstSync_ff[1] & rstSync_ff[2];
	assign periphRst_n = released;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			irs_pkg::ST_HOLD: if (released) nxt_state = irs_pkg::ST_STAB;
			irs_pkg::ST_STAB:
				if (stabCnt_ff == 32'(STAB_CYCLES - 1)) nxt_state = irs_pkg::ST_VLO;
			irs_pkg::ST_VLO:  nxt_state = irs_pkg::ST_VHI;
			irs_pkg::ST_VHI:  nxt_state = irs_pkg::ST_LOAD;
			irs_pkg::ST_LOAD: nxt_state = irs_pkg::ST_RUN;
			irs_pkg::ST_RUN:  nxt_state = irs_pkg::ST_RUN;
			default:          nxt_state = irs_pkg::ST_HOLD;
		endcase
	end

	// every release walks the vector fetch, never resumes old code
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= irs_pkg::ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stabCnt_ff <= 32'h0;
		else if (state_ff == irs_pkg::ST_STAB && nxt_state == irs_pkg::ST_STAB)
			stabCnt_ff <= stabCnt_ff + 32'h1;
	end

	assign cpuRun   = (state_ff == irs_pkg::ST_RUN);
	assign fetchReq = (state_ff == irs_pkg::ST_VLO) || (state_ff == irs_pkg::ST_VHI);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			fetchAddr <= irs_pkg::VEC_LO_ADDR;
		else if (state_ff == irs_pkg::ST_VLO)
			fetchAddr <= irs_pkg::VEC_HI_ADDR;
		else
			fetchAddr <= irs_pkg::VEC_LO_ADDR;
	end

	// low byte first, high byte second
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vecLo_ff        <= 8'h00;
			progCounter     <= 16'h0000;
			codeBankCurrent <= 8'h00;
		end
		else if (state_ff == irs_pkg::ST_VHI)
			vecLo_ff <= fetchData;
		else if (state_ff == irs_pkg::ST_LOAD)
		begin
			progCounter     <= {fetchData, vecLo_ff};
			codeBankCurrent <= newCodeBank;
		end
	end

	// the core owns these once running; general, stack and base registers and ram stay unreset
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpuFlags    <= irs_pkg::FLAGS_RST;
			newCodeBank <= irs_pkg::NEW_BANK_RST;
			cpuPages    <= {3{irs_pkg::PAGE_RST}};
		end
		else if (!cpuRun)
		begin
			cpuFlags    <= irs_pkg::FLAGS_RST;
			newCodeBank <= irs_pkg::NEW_BANK_RST;
			cpuPages    <= {3{irs_pkg::PAGE_RST}};
		end
	end

	// writes gated by cpuRun so nothing can alter the reset state early
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfgBus_ff   <= irs_pkg::CFG_BUS_RST;
			cfgStack_ff <= irs_pkg::CFG_STACK_RST;
			cfgWait_ff  <= irs_pkg::CFG_WAIT_RST;
		end
		else if (memWr && cpuRun)
		begin
			if (hit(memAddr, irs_pkg::CFG_BUS_ADDR)) cfgBus_ff <= memWrData;
			if (hit(memAddr, irs_pkg::CFG_STACK_ADDR)) cfgStack_ff <= memWrData;
			if (hit(memAddr, irs_pkg::CFG_WAIT_ADDR)) cfgWait_ff <= memWrData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memRdData <= 8'h00;
			memRdHit  <= 1'b0;
		end
		else
		begin
			memRdHit  <= memRd && (hit(memAddr, irs_pkg::CFG_BUS_ADDR) ||
				hit(memAddr, irs_pkg::CFG_STACK_ADDR) || hit(memAddr, irs_pkg::CFG_WAIT_ADDR));
			if (hit(memAddr, irs_pkg::CFG_BUS_ADDR))
				memRdData <= cfgBus_ff;
			else if (hit(memAddr, irs_pkg::CFG_STACK_ADDR))
				memRdData <= cfgStack_ff;
			else if (hit(memAddr, irs_pkg::CFG_WAIT_ADDR))
				memRdData <= cfgWait_ff;
			else
				memRdData <= 8'h00;
		end
	end

	// field decode
	assign singleChip       = !cfgBus_ff[irs_pkg::BUS_MODE_BIT];
	assign stackPageBits    = cfgStack_ff;
	assign relEn            = cfgWait_ff[irs_pkg::REL_EN_BIT];
	assign cpuClockSelect   = cfgWait_ff[irs_pkg::CLK_SEL_BIT];
	assign fastOscEnable    = cfgWait_ff[irs_pkg::FOSC_EN_BIT];
	assign regulatorControl = cfgWait_ff[1:0];

	always_comb
	begin
		for (int i = 0; i < irs_pkg::CS_EN_W; i++)
		begin
			if (!singleChip && cfgBus_ff[irs_pkg::CS_EN_LSB + i])
				csPin[i] = csDecode_n[i];
			else
				csPin[i] = csPortData[i];
		end
	end

	// slow clock or internal target never stretches; single chip has no outside
	assign waitOk = waitStart && extAccess && cpuClockSelect && !singleChip;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			waitCnt_ff <= 4'h0;
		else if (waitOk)
			waitCnt_ff <= waitStates(cfgWait_ff[irs_pkg::WAIT_LSB +: irs_pkg::WAIT_W]) >> 1;
		else if (waitCnt_ff != 4'h0)
			waitCnt_ff <= waitCnt_ff - 4'h1;
	end
	assign busWait = (waitCnt_ff != 4'h0);

	// request pin: three flops, counted once the last two agree
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reqSync_ff <= 3'h7;
			reqLow_ff  <= 1'b0;
		end
		else
		begin
			reqSync_ff <= {reqSync_ff[1:0], busRelReqPin_n};
			if (reqSync_ff[1] == reqSync_ff[2])
				reqLow_ff <= !reqSync_ff[2];
		end
	end
	assign inputPortPin = !reqLow_ff;

	// tristate first, acknowledge a cycle later; undo in reverse order.
	// a request dropped before the acknowledge is undefined for the master
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			relHiZ_ff <= 1'b0;
			relAck_ff <= 1'b0;
		end
		else if (relEn && reqLow_ff && cpuRun)
		begin
			if (!relHiZ_ff && busIdle)
				relHiZ_ff <= 1'b1;
			else if (relHiZ_ff)
				relAck_ff <= 1'b1;
		end
		else if (relAck_ff)
			relAck_ff <= 1'b0;
		else
			relHiZ_ff <= 1'b0;
	end
	assign busOe          = !relHiZ_ff;
	assign busRelAckPin_n = relEn ? !relAck_ff : ackPortData;

	a_hold_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		!released |-> !cpuRun && !fetchReq && !periphRst_n)
		else $error("cpu started before reset release");

	a_stab_full: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == irs_pkg::ST_VLO |-> stabCnt_ff == 32'(STAB_CYCLES - 1))
		else $error("vector fetch before stabilization wait ended");

	a_vector_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == irs_pkg::ST_VLO && fetchAddr == irs_pkg::VEC_LO_ADDR
		|=> fetchReq && fetchAddr == irs_pkg::VEC_HI_ADDR ##1 !fetchReq ##1 cpuRun)
		else $error("reset vector fetch out of order");

	a_pc_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == irs_pkg::ST_VHI ##1 state_ff == irs_pkg::ST_LOAD
		|=> progCounter == {$past(fetchData), $past(fetchData, 2)})
		else $error("program counter not loaded from vector");

	a_bank_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(cpuRun) |-> codeBankCurrent == irs_pkg::NEW_BANK_RST)
		else $error("code bank not copied from new bank");

	a_cpu_init: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cpuRun |-> cpuFlags == irs_pkg::FLAGS_RST && newCodeBank == irs_pkg::NEW_BANK_RST
		&& cpuPages == {3{irs_pkg::PAGE_RST}})
		else $error("cpu register reset value wrong");

	a_cfg_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cpuRun |-> cfgBus_ff == irs_pkg::CFG_BUS_RST && cfgStack_ff == irs_pkg::CFG_STACK_RST
		&& cfgWait_ff == irs_pkg::CFG_WAIT_RST)
		else $error("config register reset value wrong");

	a_cs_single: assert property (@(posedge core_clk) disable iff (!rst_n)
		singleChip |-> csPin == csPortData)
		else $error("chip select driven in single chip mode");

	a_wait_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		waitOk && cfgWait_ff[6:4] == 3'h3 |=> busWait [*3] ##1 !busWait)
		else $error("wait stretch length wrong");

	a_wait_block: assert property (@(posedge core_clk) disable iff (!rst_n)
		waitStart && (!extAccess || !cpuClockSelect) && !busWait |=> !busWait)
		else $error("wait inserted on internal or slow access");

	a_rel_order: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(relAck_ff) |-> !busOe && $past(!busOe))
		else $error("acknowledge before bus tristated");
endmodule

// ===== sim/irs_far_side.sv
// far side model: program memory answering vector reads, and an external bus master
// assumes inputs are sampled on core_clk and the master is started by the bench on goRel
module irs_far_side #(
	parameter logic [7:0] VEC_LO = 8'h34, // arbitrary vector low byte
	parameter logic [7:0] VEC_HI = 8'h12  // arbitrary vector high byte
) (
	input  wire logic        core_clk,       // core clock
	input  wire logic        fetchReq,       // vector read strobe
	input  wire logic [23:0] fetchAddr,      // vector read address
	output logic      [7:0]  fetchData,      // byte one cycle later
	input  wire logic        goRel,          // start one bus release
	input  wire logic        busRelAckPin_n, // acknowledge from device
	output logic             busRelReqPin_n  // request to device
);
	timeunit 1ns;
	timeprecision 100ps;
	int w;
	initial fetchData = 8'h5a;
	initial busRelReqPin_n = 1'b1;
	// released data bus shows a changing pattern, the last byte and its complement in turn
	always @(posedge core_clk)
	begin
		if (fetchReq)
			fetchData <= (fetchAddr == 24'h000001) ? VEC_HI : VEC_LO;
		else
			fetchData <= ~fetchData;
	end
	always @(posedge goRel)
	begin
		@(negedge core_clk);
		busRelReqPin_n = 1'b0;
		w = 0;
		while (busRelAckPin_n !== 1'b0 && w < 50)
		begin
			@(negedge core_clk);
			w++;
		end
		repeat (4) @(negedge core_clk);
		busRelReqPin_n = 1'b1;
	end
endmodule

// ===== sim/tb.sv
// self-checking bench for the initial reset sequencer and system registers
// assumes inputs change on the falling edge; far side model feeds vector and bus master
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STAB = 16;
	logic core_clk, rst_n, memWr, memRd, waitStart, extAccess, ackPortData, goRel, busIdle;
	logic cpuRun, periphRst_n, fetchReq, memRdHit, cpuClockSelect, fastOscEnable, busWait;
	logic busRelReqPin_n, inputPortPin, busRelAckPin_n, busOe;
	logic [23:0] memAddr, fetchAddr;
	logic [7:0]  memWrData, memRdData, fetchData, codeBankCurrent, newCodeBank, stackPageBits;
	logic [15:0] progCounter;
	logic [3:0]  csDecode_n, csPortData, csPin;
	logic [1:0]  regulatorControl;
	irs_pkg::irs_flags_s cpuFlags;
	irs_pkg::irs_pages_s cpuPages;
	int n_mismatch, checks, tick, k, n;
	irs_initial_reset #(.STAB_CYCLES(STAB)) irs_initial_reset_i (.core_clk, .rst_n, .cpuRun,
		.periphRst_n, .fetchReq, .fetchAddr, .fetchData, .progCounter, .codeBankCurrent,
		.newCodeBank, .cpuFlags, .cpuPages, .memAddr, .memWr, .memRd, .memWrData, .memRdData,
		.memRdHit, .stackPageBits, .cpuClockSelect, .fastOscEnable, .regulatorControl,
		.waitStart, .extAccess, .busWait, .csDecode_n, .csPortData, .csPin, .busRelReqPin_n,
		.busIdle, .ackPortData, .inputPortPin, .busRelAckPin_n, .busOe);
	irs_far_side irs_far_side_i (.core_clk, .fetchReq, .fetchAddr, .fetchData, .goRel,
		.busRelAckPin_n, .busRelReqPin_n);
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [23:0] a, input logic [7:0] d);
		@(negedge core_clk);
		memAddr = a;
		memWrData = d;
		memWr = 1'b1;
		@(negedge core_clk);
		memWr = 1'b0;
	endtask
	task rdchk(input logic [23:0] a, input logic [7:0] exp, input logic hit);
		@(negedge core_clk);
		memAddr = a;
		memRd = 1'b1;
		@(negedge core_clk);
		memRd = 1'b0;
		chk(memRdData, exp);
		chk(memRdHit, hit);
	endtask
	// counts wait cycles that follow one t3 pulse
	task waitn(input logic ext);
		@(negedge core_clk);
		waitStart = 1'b1;
		extAccess = ext;
		@(negedge core_clk);
		waitStart = 1'b0;
		n = 0;
		repeat (20)
		begin
			if (busWait === 1'b1)
				n++;
			@(negedge core_clk);
		end
	endtask
	task resetRun();
		@(negedge core_clk);
		rst_n = 1'b0;
		repeat (12) @(negedge core_clk);
		chk(cpuRun, 0);
		chk(periphRst_n, 0);
		chk(busOe, 1);
		chk(newCodeBank, irs_pkg::NEW_BANK_RST);
		chk(cpuFlags, irs_pkg::FLAGS_RST);
		chk(cpuPages, 0);
		rst_n = 1'b1;
		wr(irs_pkg::CFG_STACK_ADDR, 8'h5a);
		k = 2;
		while (cpuRun !== 1'b1 && k < 200)
		begin
			@(negedge core_clk);
			k++;
		end
		chk(k > STAB + 2, 1);
		chk(progCounter, 16'h1234);
		chk(codeBankCurrent, 8'h01);
		chk(cpuRun, 1);
		chk(periphRst_n, 1);
		rdchk(irs_pkg::CFG_STACK_ADDR, irs_pkg::CFG_STACK_RST, 1);
		$display("test reset done");
	endtask
	task results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		tick++;
		if (tick == 3000)
		begin
			n_mismatch++;
			results();
		end
	end
	initial
	begin
		{rst_n, memWr, memRd, waitStart, extAccess, goRel} = 6'h00;
		busIdle = 1'b1;
		{memAddr, memWrData, ackPortData} = 33'h000000001;
		{csDecode_n, csPortData} = 8'h96;
		resetRun();
		rdchk(irs_pkg::CFG_BUS_ADDR, irs_pkg::CFG_BUS_RST, 1);
		rdchk(irs_pkg::CFG_WAIT_ADDR, irs_pkg::CFG_WAIT_RST, 1);
		rdchk(24'h00ff03, 8'h00, 0);
		wr(irs_pkg::CFG_STACK_ADDR, 8'ha5);
		rdchk(irs_pkg::CFG_STACK_ADDR, 8'ha5, 1);
		chk(stackPageBits, 8'ha5);
		wr(irs_pkg::CFG_WAIT_ADDR, 8'h0f);
		chk({cpuClockSelect, fastOscEnable, regulatorControl}, 4'hf);
		rdchk(irs_pkg::CFG_WAIT_ADDR, 8'h0f, 1);
		ackPortData = 1'b0;
		@(negedge core_clk);
		chk(busRelAckPin_n, 0);
		ackPortData = 1'b1;
		$display("test registers done");
		wr(irs_pkg::CFG_BUS_ADDR, 8'h3f);
		chk(csPin, 4'h6);
		wr(irs_pkg::CFG_BUS_ADDR, 8'h75);
		chk(csPin, 4'h3);
		wr(irs_pkg::CFG_BUS_ADDR, 8'h7f);
		chk(csPin, 4'h9);
		$display("test chip select done");
		for (int c = 0; c < 8; c++)
		begin
			wr(irs_pkg::CFG_WAIT_ADDR, {1'b0, 3'(c), 4'h8});
			waitn(1'b1);
			chk(n, c);
		end
		waitn(1'b0);
		chk(n, 0);
		wr(irs_pkg::CFG_WAIT_ADDR, 8'h70);
		waitn(1'b1);
		chk(n, 0);
		$display("test wait done");
		wr(irs_pkg::CFG_WAIT_ADDR, 8'h88);
		chk(busOe, 1);
		busIdle = 1'b0;
		goRel = 1'b1;
		repeat (8) @(negedge core_clk);
		chk(inputPortPin, 0);
		chk({busOe, busRelAckPin_n}, 2'h3);
		busIdle = 1'b1;
		k = 0;
		while (busRelAckPin_n !== 1'b0 && k < 50)
		begin
			@(negedge core_clk);
			k++;
		end
		chk(busRelAckPin_n, 0);
		chk(busOe, 0);
		k = 0;
		while (busOe !== 1'b1 && k < 50)
		begin
			@(negedge core_clk);
			k++;
		end
		chk({busOe, busRelAckPin_n, busRelReqPin_n}, 3'h7);
		chk(inputPortPin, 1);
		$display("test bus release done");
		resetRun();
		rdchk(irs_pkg::CFG_WAIT_ADDR, irs_pkg::CFG_WAIT_RST, 1);
		$display("test second reset done");
		results();
	end
endmodule
